// ==== core/adc_sequence_buffer_control.sv ====
// Behaviour
// - calibration off: route inputs from the mux select register, or from the core's scan channel in scan mode.
// - calibration on: both sample inputs tied to the low reference.
// - scan enable bit 10 scans inputs; clear uses fixed mux selection.
// - read-only fill half bit shows which half is written in split mode.
// - interrupt after every sequences_per_interrupt plus one completed sequences.
// - split mode bit 1 gives two 8-word halves, else one 16-word buffer.
// - alternate bit: setting A first, then B, A, B; clear always A.
// - bits 11, 9-8 and 6 read zero and ignore writes.
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module adc_sequence_buffer_control
  import adc_seq_pkg::*;
#(
  // storage and counter sizes
  parameter int unsigned buf_words = adc_seq_pkg::buf_depth,
  parameter int unsigned seq_field_w = adc_seq_pkg::spi_w
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [adc_seq_pkg::data_w-1:0] hwdata,
  input wire logic hready,
  output logic [adc_seq_pkg::data_w-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // converter core side
  input wire logic conv_done,
  input wire logic [adc_seq_pkg::ch_w-1:0] scan_channel,
  output logic [adc_seq_pkg::ch_w-1:0] mux_pos,
  output logic mux_neg_low_ref,
  output logic scan_active,
  output logic result_we,
  output logic [adc_seq_pkg::idx_w-1:0] result_index,
  // interrupt
  output logic irq
);
  import adc_seq_pkg::*;

  // index and counter widths are fixed in the package, so only these sizes are served
  if (buf_words != buf_depth || seq_field_w != spi_w)
  begin : g_bad_size
    $error("unsupported buffer depth or sequence field width");
  end

  function automatic logic [ch_w-1:0] pick_channel(input logic cal, input logic scan,
                                                   input logic use_b,
                                                   input logic [ch_w-1:0] sel_a,
                                                   input logic [ch_w-1:0] sel_b,
                                                   input logic [ch_w-1:0] scan_ch);
    if (cal)
      pick_channel = low_ref_code;
    else if (scan)
      pick_channel = scan_ch;
    else if (use_b)
      pick_channel = sel_b;
    else
      pick_channel = sel_a;
  endfunction : pick_channel

  // bus state
  logic ph_write, ph_read;
  logic [addr_w-1:0] ph_addr;
  logic next_ph_write, next_ph_read;
  logic [addr_w-1:0] next_ph_addr;
  logic [15:0] ctrl;
  logic [15:0] next_ctrl;
  logic [ev_w-1:0] status, mask, next_status, next_mask;
  logic [15:0] mux_sel, next_mux_sel;
  logic [31:0] next_hrdata;
  // sequencing state
  logic [spi_w-1:0] seq_count, next_seq_count;
  logic fill_half, next_fill_half;
  logic use_b, next_use_b;
  logic [idx_w-1:0] word_ptr, next_word_ptr;
  logic next_result_we;
  logic [idx_w-1:0] next_result_index;
  logic [ch_w-1:0] next_mux_pos;
  logic next_mux_neg, next_scan_active, next_irq;
  logic group_event;
  logic [ev_w-1:0] ev_set;
  mux_mode_t mode;

  // addresses above the map are not taken: reads give zero and writes are dropped
  wire logic in_map = haddr[31:addr_w] == '0;
  wire logic take = hsel && hready && htrans == htrans_nonseq && hsize == hsize_word && in_map;
  wire logic [spi_w-1:0] spi = ctrl[spi_lo +: spi_w];
  wire logic split = ctrl[split_bit];

  always_comb
  begin
    if (ctrl[offset_calibration_enable_bit])
      mode = mux_calibrate;
    else if (ctrl[scan_bit])
      mode = mux_scan;
    else if (ctrl[alt_bit])
      mode = mux_alternate;
    else
      mode = mux_fixed;
  end

  // sequence bookkeeping
  always_comb
  begin
    group_event = conv_done && seq_count == spi;
    next_seq_count = seq_count;
    next_fill_half = fill_half;
    next_use_b = use_b;
    next_word_ptr = word_ptr;
    next_result_we = conv_done;
    next_result_index = result_index;
    if (conv_done)
    begin
      if (split)
        next_result_index = (fill_half ? half_base : '0) | {1'b0, word_ptr[idx_w-2:0]};
      else
        next_result_index = word_ptr;
      next_use_b = (mode == mux_alternate) ? !use_b : 1'b0;
      if (group_event)
      begin
        next_seq_count = '0;
        next_word_ptr = '0;
        if (split)
          next_fill_half = !fill_half;
      end
      else
      begin
        next_seq_count = seq_count + 1'b1;
        next_word_ptr = word_ptr + 1'b1;
      end
    end
    if (!split)
      next_fill_half = 1'b0;
    if (mode != mux_alternate)
      next_use_b = 1'b0;
    case (mode)
      mux_calibrate: next_mux_pos = low_ref_code;
      mux_scan: next_mux_pos = pick_channel(1'b0, 1'b1, 1'b0, '0, '0, scan_channel);
      mux_alternate: next_mux_pos = pick_channel(1'b0, 1'b0, next_use_b, mux_sel[ch_w-1:0],
                                                 mux_sel[mux_b_lo +: ch_w], '0);
      mux_fixed: next_mux_pos = mux_sel[ch_w-1:0];
      default: next_mux_pos = mux_sel[ch_w-1:0];
    endcase
    next_mux_neg = mode == mux_calibrate;
    next_scan_active = mode == mux_scan;
  end

  // bus and register file
  always_comb
  begin
    next_ph_write = 1'b0;
    next_ph_read = 1'b0;
    next_ph_addr = ph_addr;
    next_ctrl = ctrl;
    next_mask = mask;
    next_mux_sel = mux_sel;
    next_hrdata = '0;
    ev_set = '0;
    ev_set[ev_seq] = conv_done;
    ev_set[ev_group] = group_event;
    next_status = status;
    if (take)
    begin
      next_ph_write = hwrite;
      next_ph_read = !hwrite;
      next_ph_addr = haddr[addr_w-1:0];
      if (!hwrite)
        case (haddr[addr_w-1:0])
          ctrl_two_addr: next_hrdata = {16'h0000, ctrl[15:8], fill_half, 1'b0, ctrl[5:0]};
          status_addr: next_hrdata = {{(32-ev_w){1'b0}}, status};
          mask_addr: next_hrdata = {{(32-ev_w){1'b0}}, mask};
          mux_addr: next_hrdata = {16'h0000, mux_sel};
          default: next_hrdata = '0;
        endcase
    end
    if (ph_write)
      case (ph_addr)
        ctrl_two_addr: next_ctrl = hwdata[15:0] & ctrl_write_mask;
        status_addr: next_status = status & ~hwdata[ev_w-1:0];
        mask_addr: next_mask = hwdata[ev_w-1:0];
        mux_addr: next_mux_sel = hwdata[15:0] & mux_sel_mask;
        default: ;
      endcase
    // a new event wins over a simultaneous write-one-to-clear
    next_status = next_status | ev_set;
    next_irq = |(next_status & next_mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_write <= 1'b0;
      ph_read <= 1'b0;
      ph_addr <= '0;
      ctrl <= ctrl_reset;
      status <= '0;
      mask <= '0;
      mux_sel <= '0;
      hrdata <= '0;
      seq_count <= '0;
      fill_half <= 1'b0;
      use_b <= 1'b0;
      word_ptr <= '0;
      result_we <= 1'b0;
      result_index <= '0;
      mux_pos <= '0;
      mux_neg_low_ref <= 1'b0;
      scan_active <= 1'b0;
      irq <= 1'b0;
      // zero wait states and always okay, still registered like every output
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      ph_write <= next_ph_write;
      ph_read <= next_ph_read;
      ph_addr <= next_ph_addr;
      ctrl <= next_ctrl;
      status <= next_status;
      mask <= next_mask;
      mux_sel <= next_mux_sel;
      hrdata <= next_hrdata;
      seq_count <= next_seq_count;
      fill_half <= next_fill_half;
      use_b <= next_use_b;
      word_ptr <= next_word_ptr;
      result_we <= next_result_we;
      result_index <= next_result_index;
      mux_pos <= next_mux_pos;
      mux_neg_low_ref <= next_mux_neg;
      scan_active <= next_scan_active;
      irq <= next_irq;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  a_cal_low_ref: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(ctrl[offset_calibration_enable_bit]) |-> mux_neg_low_ref && mux_pos == low_ref_code)
    else $error("calibration did not tie inputs to low reference");
  a_scan_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(ctrl[scan_bit] && !ctrl[offset_calibration_enable_bit]) |-> scan_active && mux_pos == $past(scan_channel))
    else $error("scan mode did not follow scan channel");
  a_fixed_route: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(mode == mux_fixed) |-> mux_pos == $past(mux_sel[ch_w-1:0]))
    else $error("fixed mode did not use setting a");
  a_cal_off_neg: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(!ctrl[offset_calibration_enable_bit]) |-> !mux_neg_low_ref)
    else $error("negative input left on low reference");
  a_unimpl_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ctrl[11] == 1'b0 && ctrl[9:8] == 2'b00 && ctrl[6] == 1'b0 && ctrl[7] == 1'b0)
    else $error("unimplemented control bit set");
  a_read_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    ph_read && ph_addr == ctrl_two_addr |-> hrdata[31:16] == 16'h0000 && hrdata[11] == 1'b0
      && hrdata[9:8] == 2'b00 && hrdata[6] == 1'b0)
    else $error("unimplemented control bit read as one");
  a_write_mask: assert property (@(posedge hclk) disable iff (!hresetn)
    ph_write && ph_addr == ctrl_two_addr |=> ctrl == ($past(hwdata[15:0]) & ctrl_write_mask))
    else $error("control write not masked to writable bits");
  a_half_swap: assert property (@(posedge hclk) disable iff (!hresetn)
    group_event && split |=> fill_half != $past(fill_half))
    else $error("fill half did not swap on event");
  a_split_index: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && split |=> result_we && result_index[idx_w-1] == $past(fill_half))
    else $error("split write went to wrong half");
  a_split_low: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && split && !fill_half |=> result_index < half_base)
    else $error("low half fill wrote into high half");
  a_single_restart: assert property (@(posedge hclk) disable iff (!hresetn)
    group_event && !split |=> word_ptr == '0)
    else $error("single buffer did not restart at word zero");
  a_single_index: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && !split |=> result_index == $past(word_ptr))
    else $error("single buffer word out of order");
  a_we_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    result_we == $past(conv_done))
    else $error("result write not one cycle after completion");
  a_group_count: assert property (@(posedge hclk) disable iff (!hresetn)
    group_event |-> conv_done && seq_count == spi ##1 status[ev_group])
    else $error("group event count mismatch");
  a_seq_flag: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done |=> status[ev_seq])
    else $error("sequence status not set");
  a_irq_follows: assert property (@(posedge hclk) disable iff (!hresetn)
    irq == |(status & mask))
    else $error("interrupt does not follow masked status");
  a_alt_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    conv_done && mode == mux_alternate && $stable(ctrl) |=> use_b != $past(use_b))
    else $error("alternate setting did not toggle");
  a_alt_off: assert property (@(posedge hclk) disable iff (!hresetn)
    mode != mux_alternate |=> !use_b)
    else $error("setting b used outside alternate mode");
  a_split_off_half: assert property (@(posedge hclk) disable iff (!hresetn)
    !$past(split) |-> !fill_half)
    else $error("fill half set outside split mode");
endmodule : adc_sequence_buffer_control
`default_nettype wire

// ==== shared/adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;
  localparam int unsigned data_w = 32;
  localparam int unsigned addr_w = 4;
  // byte offsets of the register map
  localparam logic [addr_w-1:0] ctrl_two_addr = 4'h0;
  localparam logic [addr_w-1:0] status_addr = 4'h4;
  localparam logic [addr_w-1:0] mask_addr = 4'h8;
  localparam logic [addr_w-1:0] mux_addr = 4'hc;
  // control register two field positions
  localparam int unsigned vref_cfg_lo = 13;
  localparam int unsigned offset_calibration_enable_bit = 12;
  localparam int unsigned scan_bit = 10;
  localparam int unsigned fill_half_bit = 7;
  localparam int unsigned spi_lo = 2;
  localparam int unsigned spi_w = 4;
  localparam int unsigned split_bit = 1;
  localparam int unsigned alt_bit = 0;
  // writable bits: 15-12, 10, 5-0; bit 7 is read-only
  localparam logic [15:0] ctrl_write_mask = 16'hf43f;
  localparam logic [15:0] ctrl_reset = 16'h0000;
  // interrupt status layout
  localparam int unsigned ev_w = 2;
  localparam int unsigned ev_seq = 0;
  localparam int unsigned ev_group = 1;
  // mux select word layout: setting a in [4:0], setting b in [12:8]
  localparam int unsigned ch_w = 5;
  localparam int unsigned mux_b_lo = 8;
  localparam logic [15:0] mux_sel_mask = 16'h1f1f;
  localparam logic [ch_w-1:0] low_ref_code = 5'h1f;
  localparam int unsigned buf_depth = 16;
  localparam int unsigned idx_w = 4;
  localparam logic [idx_w-1:0] half_base = 4'h8;
  localparam logic [1:0] htrans_nonseq = 2'h2;
  localparam logic [2:0] hsize_word = 3'h2;
  typedef enum logic [1:0] {
    mux_fixed = 2'b00,
    mux_alternate = 2'b01,
    mux_scan = 2'b10,
    mux_calibrate = 2'b11
  } mux_mode_t;
endpackage : adc_seq_pkg
`default_nettype wire

// ==== test/conv_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module conv_core_model (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // burst request from the bench
  input wire logic start,
  input wire logic [4:0] count,
  input wire logic slow,
  // converter side
  output logic conv_done,
  output logic [4:0] scan_channel,
  output logic busy
);
  logic [4:0] left;
  logic [1:0] gap;
  // slow bursts leave two idle cycles between sequences, fast ones none
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      left <= 5'h00;
      gap <= 2'h0;
      conv_done <= 1'b0;
      scan_channel <= 5'h00;
    end
    else
    begin
      conv_done <= 1'b0;
      if (start)
        left <= count;
      else if (left != 5'h00 && (gap == 2'h0 || !slow))
      begin
        conv_done <= 1'b1;
        left <= left - 5'h01;
        scan_channel <= scan_channel + 5'h01;
        gap <= 2'h2;
      end
      else if (gap != 2'h0)
        gap <= gap - 2'h1;
    end
  end
  assign busy = (left != 5'h00) || conv_done;
endmodule : conv_core_model
`default_nettype wire

// ==== test/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import adc_seq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_done, start, slow, busy;
  logic mux_neg_low_ref, scan_active, result_we, irq;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [4:0] scan_channel, mux_pos, count;
  logic [3:0] result_index;
  logic [31:0] idx_q[$], mux_q[$];
  int mismatches = 0;
  int samples_checked = 0;
  adc_sequence_buffer_control DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_done(conv_done),
    .scan_channel(scan_channel), .mux_pos(mux_pos), .mux_neg_low_ref(mux_neg_low_ref),
    .scan_active(scan_active), .result_we(result_we), .result_index(result_index), .irq(irq));
  conv_core_model core (.hclk(hclk), .hresetn(hresetn), .start(start), .count(count),
    .slow(slow), .conv_done(conv_done), .scan_channel(scan_channel), .busy(busy));
  always @(posedge hclk)
  begin
    if (result_we === 1'b1)
      idx_q.push_back({28'h0000000, result_index});
    if (conv_done === 1'b1)
      mux_q.push_back({27'h0000000, mux_pos});
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // only the watchdog ends a wait that never sees hready
  task automatic wait_ready;
    @(posedge hclk);
    while (hreadyout !== 1'b1)
      @(posedge hclk);
  endtask : wait_ready
  // one single word transfer; outputs get two edges to settle afterwards
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= htrans_nonseq;
    hwrite <= w;
    hsize <= hsize_word;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    r = hrdata;
    repeat (2) @(posedge hclk);
  endtask : bus
  task automatic run(input logic [4:0] n, input logic s);
    int i;
    @(posedge hclk);
    start <= 1'b1;
    count <= n;
    slow <= s;
    @(posedge hclk);
    start <= 1'b0;
    @(posedge hclk);
    for (i = 0; i < 200 && busy === 1'b1; i++)
      @(posedge hclk);
    chk("core idle", 32'h0, busy);
    repeat (3) @(posedge hclk);
  endtask : run
  task automatic t_regs;
    bus(0, ctrl_two_addr, 0);
    chk("ctrl reset", {16'h0000, ctrl_reset}, r);
    chk("okay", 32'h0, hresp);
    bus(1, ctrl_two_addr, 32'hffffffff);
    bus(0, ctrl_two_addr, 0);
    chk("ctrl writable", {16'h0000, ctrl_write_mask}, r);
    bus(0, 32'h00000010, 0);
    chk("unmapped", 32'h00000000, r);
    bus(1, 32'h00000010, 0);
    bus(0, ctrl_two_addr, 0);
    chk("ctrl kept", {16'h0000, ctrl_write_mask}, r);
    bus(1, ctrl_two_addr, 0);
    bus(1, mask_addr, 32'hffffffff);
    bus(0, mask_addr, 0);
    chk("mask", 32'h00000003, r);
  endtask : t_regs
  task automatic t_mux;
    bus(1, mux_addr, 32'h00000503);
    chk("mux fixed", 32'h3, mux_pos);
    chk("neg ref", 32'h0, mux_neg_low_ref);
    chk("scan off", 32'h0, scan_active);
    bus(1, ctrl_two_addr, 32'h00001000);
    chk("mux cal", 32'h1f, mux_pos);
    chk("neg cal", 32'h1, mux_neg_low_ref);
    bus(1, ctrl_two_addr, 32'h00000400);
    chk("scan on", 32'h1, scan_active);
    chk("scan mux", scan_channel, mux_pos);
    bus(1, ctrl_two_addr, 32'h00000001);
    mux_q.delete();
    run(4, 1);
    chk("alt count", 32'h4, mux_q.size());
    for (int i = 0; i < 4; i++)
      chk("alt mux", (i % 2 == 1) ? 32'h5 : 32'h3, mux_q[i]);
  endtask : t_mux
  task automatic t_single;
    bus(1, mask_addr, 32'h00000002);
    bus(1, ctrl_two_addr, 32'h00000008);
    bus(1, status_addr, 32'h00000003);
    idx_q.delete();
    run(2, 1);
    chk("irq early", 32'h0, irq);
    run(1, 1);
    chk("irq group", 32'h1, irq);
    bus(0, status_addr, 0);
    chk("status", 32'h3, r);
    bus(1, status_addr, 32'h00000003);
    chk("irq clear", 32'h0, irq);
    run(3, 1);
    chk("word count", 32'h6, idx_q.size());
    for (int i = 0; i < 6; i++)
      chk("word index", i % 3, idx_q[i]);
    bus(1, status_addr, 32'h00000003);
    bus(1, ctrl_two_addr, 32'h0000003c);
    run(15, 0);
    chk("irq fifteen", 32'h0, irq);
    run(1, 0);
    chk("irq sixteen", 32'h1, irq);
  endtask : t_single
  task automatic t_split;
    bus(1, status_addr, 32'h00000003);
    bus(1, ctrl_two_addr, 32'h00000002);
    bus(0, ctrl_two_addr, 0);
    chk("half low", 32'h2, r);
    idx_q.delete();
    run(1, 0);
    chk("irq every", 32'h1, irq);
    bus(0, ctrl_two_addr, 0);
    chk("half high", 32'h82, r);
    chk("read half", 32'h1, {31'h0, idx_q[0][idx_w-1] != r[fill_half_bit]});
    run(1, 0);
    bus(0, ctrl_two_addr, 0);
    chk("half back", 32'h2, r);
    chk("first half", 32'h0, idx_q[0]);
    chk("second half", 32'h8, idx_q[1]);
  endtask : t_split
  task print_verdict;
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : print_verdict
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // far longer than the whole sequence needs, so only a hang reaches it
  initial
  begin
    #(50 * 20000);
    mismatches++;
    print_verdict();
  end
  initial
  begin
    {hresetn, hsel, hwrite, start, slow} = 5'h00;
    {haddr, hwdata, htrans, hsize, count} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_mux();
    t_single();
    t_split();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
